/* File: nco_regs.svh */
`ifndef NCO_REGS_SVH
`define NCO_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define NCO_OFS_TUNING     8'h00
`define NCO_OFS_CONTROL    8'h04
`define NCO_OFS_STATUS     8'h08
`define NCO_OFS_ACTIVE_FTW 8'h0c
`define NCO_OFS_PHASE_ACC  8'h10

// ****************************************
// control byte fields
// ****************************************
`define NCO_CTL_MULT_BIT   0
`define NCO_CTL_TEST_BIT   1
`define NCO_CTL_PD_BIT     2
`define NCO_CTL_PHASE_LSB  3
`define NCO_CTL_PHASE_MSB  7

// ****************************************
// status word fields
// ****************************************
`define NCO_STS_PHASE_LSB  0
`define NCO_STS_PHASE_MSB  4
`define NCO_STS_MULT_BIT   5
`define NCO_STS_PD_BIT     6
`define NCO_STS_LOST_BIT   7
`define NCO_STS_PEND_BIT   8

// ****************************************
// reset values
// ****************************************
`define NCO_RST_ACC        32'h0000_0000
`define NCO_RST_FTW        32'h0000_0000
`define NCO_RST_PHASE      5'h00

// ****************************************
// timing
// ****************************************
`define NCO_CLK_HZ         10000000
`define NCO_REF_MIN_DIR_HZ 1000000
`define NCO_REF_MIN_MUL_HZ 5000000
`define NCO_RESUME_NS      5000
`define NCO_RESUME_CYC     ((`NCO_RESUME_NS * (`NCO_CLK_HZ / 1000000)) / 1000)
`define NCO_GAP_DIR_CYC    (`NCO_CLK_HZ / `NCO_REF_MIN_DIR_HZ)
`define NCO_GAP_MUL_CYC    (`NCO_CLK_HZ / `NCO_REF_MIN_MUL_HZ)
`define NCO_LAT_FREQ_CYC   18
`define NCO_LAT_PHASE_CYC  13

`endif

/* File: nco_pkg.sv */
`default_nettype none

package nco_pkg;

  // reference clock supervision
  typedef enum logic [1:0] {
    st_run,
    st_lost,
    st_resume
  } clock_state_type;

  typedef logic [31:0] phase_word_type;
  typedef logic [9:0]  amp_type;

endpackage

`default_nettype wire

/* File: nco_skid_buffer.sv */
`timescale 1ns/100ps
`default_nettype none

module nco_skid_buffer #(
  parameter int WIDTH = 20
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic             skid_valid_q;
  logic [WIDTH-1:0] skid_data_q;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic             pop;
  logic             push;

  // full when the second entry holds a word
  assign in_ready  = !skid_valid_q;
  assign pop       = out_ready || !out_valid_q;
  assign push      = in_valid && in_ready;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  // ****************************************
  // head entry, drives the outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (pop) begin
      if (skid_valid_q) begin
        out_valid_q <= 1'b1;
        out_data_q  <= skid_data_q;
      end else begin
        out_valid_q <= push;
        if (push) begin
          out_data_q <= in_data;
        end
      end
    end
  end

  // ****************************************
  // second entry, catches a word on stall
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      skid_valid_q <= 1'b0;
      skid_data_q  <= '0;
    end else if (pop) begin
      skid_valid_q <= 1'b0;
    end else if (push) begin
      skid_valid_q <= 1'b1;
      skid_data_q  <= in_data;
    end
  end

endmodule

`default_nettype wire

/* File: dds_nco_core.sv */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

`include "nco_regs.svh"

module dds_nco_core
  import nco_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              write_strobe,
  input  wire logic              read_strobe,
  output logic [31:0]            rdata,
  // pins from the outside
  input  wire logic              core_update_strobe,
  input  wire logic              reference_clock_in,
  // amplitude stream to the converter
  output logic [9:0]             dac_true_output,
  output logic [9:0]             dac_complement_output,
  output logic                   dac_valid,
  input  wire logic              dac_ready,
  // status pins
  output logic                   comparator_enable,
  output logic                   mult_engaged,
  output logic                   powered_down
);

  // ****************************************
  // constants
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_TUNING  = ADDR_W'(`NCO_OFS_TUNING);
  localparam logic [ADDR_W-1:0] OFS_CONTROL = ADDR_W'(`NCO_OFS_CONTROL);
  localparam logic [ADDR_W-1:0] OFS_STATUS  = ADDR_W'(`NCO_OFS_STATUS);
  localparam logic [ADDR_W-1:0] OFS_FTW     = ADDR_W'(`NCO_OFS_ACTIVE_FTW);
  localparam logic [ADDR_W-1:0] OFS_ACC     = ADDR_W'(`NCO_OFS_PHASE_ACC);
  localparam logic [5:0] GAP_DIR    = 6'(`NCO_GAP_DIR_CYC);
  localparam logic [5:0] GAP_MUL    = 6'(`NCO_GAP_MUL_CYC);
  localparam logic [6:0] RESUME_CYC = 7'(`NCO_RESUME_CYC);
  localparam logic [4:0] LAT_FREQ   = 5'(`NCO_LAT_FREQ_CYC);
  localparam logic [4:0] LAT_PHASE  = 5'(`NCO_LAT_PHASE_CYC);

  // ****************************************
  // helpers
  // ****************************************

  // pin synchroniser step: new level once stages two and three agree
  function automatic logic settle(input logic s2, input logic s3,
                                  input logic prev);
    return (s2 == s3) ? s3 : prev;
  endfunction

  // cosine shape so that phase zero gives full scale; a parabola per
  // half wave stands in for a table, trading a few percent of accuracy
  function automatic amp_type phase_to_amp(input logic [13:0] ph);
    logic [13:0] q;
    logic [12:0] h;
    logic [25:0] p;
    logic [9:0]  m;
    q = ph + 14'h1000;
    h = q[12:0];
    p = {13'h0000, h} * {12'h000, 14'h2000 - {1'b0, h}};
    m = p[24:15];
    if (m > 10'h1ff) begin
      m = 10'h1ff;
    end
    return q[13] ? (10'h200 - m) : (10'h200 + m);
  endfunction

  // ****************************************
  // input register and register port
  // ****************************************
  logic [31:0] tuning_in_q;   // staged tuning word
  logic [7:0]  control_in_q;  // staged control byte
  logic [31:0] rdata_q;

  // staged word is deliberately kept across reset
  always_ff @(posedge clk) begin
    if (write_strobe && addr == OFS_TUNING) begin
      tuning_in_q <= wdata;
    end
    if (write_strobe && addr == OFS_CONTROL) begin
      control_in_q <= wdata[7:0];
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] upd_sync_q;
  logic       upd_level_q;
  logic       upd_level_d;
  logic       upd_edge;
  logic [2:0] ref_sync_q;
  logic       ref_level_q;
  logic       ref_level_d;
  logic       ref_edge;

  // three stages on each pin
  always_ff @(posedge clk) begin
    if (srst) begin
      upd_sync_q  <= 3'h0;
      upd_level_q <= 1'b0;
      ref_sync_q  <= 3'h0;
      ref_level_q <= 1'b0;
    end else begin
      upd_sync_q  <= {upd_sync_q[1:0], core_update_strobe};
      upd_level_q <= upd_level_d;
      ref_sync_q  <= {ref_sync_q[1:0], reference_clock_in};
      ref_level_q <= ref_level_d;
    end
  end

  assign upd_level_d = settle(upd_sync_q[1], upd_sync_q[2], upd_level_q);
  assign ref_level_d = settle(ref_sync_q[1], ref_sync_q[2], ref_level_q);
  assign upd_edge    = upd_level_d && !upd_level_q;
  assign ref_edge    = ref_level_d && !ref_level_q;

  // ****************************************
  // update transfer with output latency
  // ****************************************
  logic [31:0] pend_ftw_q;
  logic [7:0]  pend_ctl_q;
  logic [4:0]  lat_cnt_q;
  logic        lat_busy_q;
  logic [31:0] ftw_q;
  logic [4:0]  phase_off_q;
  logic        pd_q;
  logic        mult_q;
  logic        test_q;

  // a later update restarts the count with the newer word
  always_ff @(posedge clk) begin
    if (srst) begin
      lat_busy_q <= 1'b0;
      lat_cnt_q  <= 5'h00;
      pend_ftw_q <= `NCO_RST_FTW;
      pend_ctl_q <= 8'h00;
    end else if (upd_edge) begin
      lat_busy_q <= 1'b1;
      lat_cnt_q  <= 5'h01;
      pend_ftw_q <= tuning_in_q;
      pend_ctl_q <= control_in_q;
    end else if (lat_busy_q) begin
      lat_cnt_q <= lat_cnt_q + 5'h01;
      if (lat_cnt_q == LAT_FREQ) begin
        lat_busy_q <= 1'b0;
      end
    end
  end

  // control byte lands with the phase, tuning word later
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_off_q <= `NCO_RST_PHASE;
      pd_q        <= 1'b0;
      mult_q      <= 1'b0;
      test_q      <= 1'b0;
      ftw_q       <= `NCO_RST_FTW;
    end else if (lat_busy_q) begin
      if (lat_cnt_q == LAT_PHASE) begin
        phase_off_q <= pend_ctl_q[`NCO_CTL_PHASE_MSB:`NCO_CTL_PHASE_LSB];
        pd_q        <= pend_ctl_q[`NCO_CTL_PD_BIT];
        mult_q      <= pend_ctl_q[`NCO_CTL_MULT_BIT];
        test_q      <= pend_ctl_q[`NCO_CTL_TEST_BIT];
      end
      if (lat_cnt_q == LAT_FREQ) begin
        ftw_q <= pend_ftw_q;
      end
    end
  end

  // ****************************************
  // reference clock supervision
  // ****************************************
  clock_state_type clk_state_q;
  logic [5:0]      gap_q;
  logic [5:0]      gap_limit;
  logic [6:0]      resume_cnt_q;
  logic            too_slow;

  // threshold follows the multiplier setting
  assign gap_limit = mult_q ? GAP_MUL : GAP_DIR;
  assign too_slow  = (gap_q >= gap_limit);

  // cycles since the last reference rising edge, saturating
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_q <= 6'h00;
    end else if (ref_edge) begin
      gap_q <= 6'h00;
    end else if (gap_q != 6'h3f) begin
      gap_q <= gap_q + 6'h01;
    end
  end

  // run, lost, resume after a fixed wait
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_state_q  <= st_run;
      resume_cnt_q <= 7'h00;
    end else begin
      unique case (clk_state_q)
        st_run: begin
          if (too_slow) begin
            clk_state_q <= st_lost;
          end
        end
        st_lost: begin
          if (ref_edge && !too_slow) begin
            clk_state_q  <= st_resume;
            resume_cnt_q <= 7'h00;
          end
        end
        st_resume: begin
          if (too_slow) begin
            clk_state_q <= st_lost;
          end else if (resume_cnt_q == RESUME_CYC - 7'h01) begin
            clk_state_q <= st_run;
          end else begin
            resume_cnt_q <= resume_cnt_q + 7'h01;
          end
        end
      endcase
    end
  end

  // ****************************************
  // phase accumulator and amplitude path
  // ****************************************
  phase_word_type acc_q;
  logic           run;
  logic           buf_in_ready;
  logic [13:0]    phase14;
  amp_type        amp;
  logic [19:0]    sample;

  // frozen by power-down, lost clock or a full buffer
  assign run = (clk_state_q == st_run) && !pd_q && buf_in_ready;

  // wraps modulo 2^32 with no compare or clear
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q <= `NCO_RST_ACC;
    end else if (run) begin
      acc_q <= acc_q + ftw_q;
    end
  end

  // offset joins the top five bits, then truncate to 14
  assign phase14 = acc_q[31:18] + {phase_off_q, 9'h000};
  assign amp     = phase_to_amp(phase14);
  assign sample  = {amp, 10'h3ff - amp};

  // ****************************************
  // two-entry buffer towards the converter
  // ****************************************
  logic [19:0] buf_out_data;

  nco_skid_buffer #(
    .WIDTH (20)
  ) u_buf (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (run),
    .in_ready  (buf_in_ready),
    .in_data   (sample),
    .out_valid (dac_valid),
    .out_ready (dac_ready),
    .out_data  (buf_out_data)
  );

  assign dac_true_output       = buf_out_data[19:10];
  assign dac_complement_output = buf_out_data[9:0];

  // ****************************************
  // status pins
  // ****************************************
  logic comp_en_q;
  logic mult_out_q;
  logic pd_out_q;

  // comparator off whenever the clock is missing
  always_ff @(posedge clk) begin
    if (srst) begin
      comp_en_q  <= 1'b1;
      mult_out_q <= 1'b0;
      pd_out_q   <= 1'b0;
    end else begin
      comp_en_q  <= (clk_state_q == st_run);
      mult_out_q <= mult_q;
      pd_out_q   <= pd_q || (clk_state_q != st_run);
    end
  end

  assign comparator_enable = comp_en_q;
  assign mult_engaged      = mult_out_q;
  assign powered_down      = pd_out_q;

  // ****************************************
  // register read back
  // ****************************************
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`NCO_STS_PHASE_MSB:`NCO_STS_PHASE_LSB] = phase_off_q;
    status_word[`NCO_STS_MULT_BIT] = mult_q;
    status_word[`NCO_STS_PD_BIT]   = pd_q;
    status_word[`NCO_STS_LOST_BIT] = (clk_state_q != st_run);
    status_word[`NCO_STS_PEND_BIT] = lat_busy_q;
  end

  // data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (read_strobe) begin
      unique case (addr)
        OFS_TUNING:  rdata_q <= tuning_in_q;
        OFS_CONTROL: rdata_q <= {24'h000000, control_in_q};
        OFS_STATUS:  rdata_q <= status_word;
        OFS_FTW:     rdata_q <= ftw_q;
        OFS_ACC:     rdata_q <= acc_q;
        default:     rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;

endmodule

`default_nettype wire

/* File: dds_nco_core_sva.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// port checker for the oscillator core
// ****************************************
module dds_nco_core_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // pins and stream
  input wire logic        core_update_strobe,
  input wire logic        reference_clock_in,
  input wire logic [9:0]  dac_true_output,
  input wire logic [9:0]  dac_complement_output,
  input wire logic        dac_valid,
  input wire logic        dac_ready,
  input wire logic        comparator_enable,
  input wire logic        mult_engaged,
  input wire logic        powered_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic       ref_q;
  logic [7:0] gap_q;
  logic [7:0] ok_q;

  // raw reference gaps; no synchroniser, so bounds carry slack
  always_ff @(posedge clk) begin
    ref_q <= reference_clock_in;
    if (srst || (reference_clock_in && !ref_q)) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    if (srst || gap_q >= 8'h0b) ok_q <= 8'h00;
    else if (ok_q != 8'hff) ok_q <= ok_q + 8'h01;
  end

  a_reset_phase: assert property ($fell(srst) |-> ##3 dac_true_output == 10'h3ff)
    else $error("first sample after reset not full scale");
  a_comp_pair: assert property (dac_valid |-> dac_complement_output == 10'h3ff - dac_true_output)
    else $error("complement sample mismatch");
  a_stall_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_true_output))
    else $error("sample lost under stall");
  a_amp_range: assert property (dac_valid |-> dac_true_output != 10'h000)
    else $error("amplitude out of range");
  a_loss_comp: assert property (!comparator_enable |-> powered_down)
    else $error("comparator off outside power-down");
  a_ref_loss: assert property (gap_q >= 8'h14 |-> powered_down && !comparator_enable)
    else $error("missing reference not detected");
  a_resume_wait: assert property ($rose(comparator_enable) |-> ok_q >= 8'h2d)
    else $error("resumed too early");
  a_update_quiet: assert property ($rose(core_update_strobe) |=> $stable(mult_engaged)[*8])
    else $error("update took effect too early");
  a_pd_freeze: assert property (powered_down[*6] |-> $past(dac_true_output) == $past(dac_true_output, 2))
    else $error("amplitude moved in power-down");
endmodule

bind dds_nco_core dds_nco_core_sva u_dds_nco_core_sva (
  .clk(clk), .srst(srst), .core_update_strobe(core_update_strobe),
  .reference_clock_in(reference_clock_in), .dac_valid(dac_valid),
  .dac_true_output(dac_true_output), .dac_ready(dac_ready),
  .dac_complement_output(dac_complement_output),
  .comparator_enable(comparator_enable), .mult_engaged(mult_engaged),
  .powered_down(powered_down));

`default_nettype wire

/* File: nco_dac_sink.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// converter input model
// ****************************************
module nco_dac_sink (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // stall request from the bench
  input  wire logic        stall,
  // sample stream
  input  wire logic        dac_valid,
  output logic             dac_ready,
  output logic [15:0]      count_q
);
  // ready drops only when the bench asks for a stall
  assign dac_ready = !stall;

  // one sample taken on each handshake edge
  always_ff @(posedge clk) begin
    if (srst) count_q <= 16'h0000;
    else if (dac_valid && dac_ready) count_q <= count_q + 16'h0001;
  end
endmodule

`default_nettype wire

/* File: test_dds_nco_core.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nco_regs.svh"

// ****************************************
// bench for the oscillator core
// ****************************************
module test_dds_nco_core;
  localparam logic [31:0] FTW_A = 32'hc000_0001;
  localparam logic [31:0] FTW_B = 32'h0000_1000;
  logic        clk;
  logic        srst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        write_strobe;
  logic        read_strobe;
  logic [31:0] rdata;
  logic        core_update_strobe;
  logic        reference_clock_in;
  logic [9:0]  dac_true_output;
  logic [9:0]  dac_complement_output;
  logic        dac_valid;
  logic        dac_ready;
  logic        comparator_enable;
  logic        mult_engaged;
  logic        powered_down;
  logic        stall;
  logic        ref_run;
  logic [15:0] count_q;
  logic [31:0] v1;
  logic [31:0] v2;
  int          errors;
  int          checks_done;
  int          n;

  dds_nco_core u_dds_nco_core (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
    .core_update_strobe(core_update_strobe),
    .reference_clock_in(reference_clock_in),
    .dac_true_output(dac_true_output),
    .dac_complement_output(dac_complement_output),
    .dac_valid(dac_valid), .dac_ready(dac_ready),
    .comparator_enable(comparator_enable), .mult_engaged(mult_engaged),
    .powered_down(powered_down));

  nco_dac_sink u_nco_dac_sink (
    .clk(clk), .srst(srst), .stall(stall), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .count_q(count_q));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end

  // reference rises every fourth clock, well above the direct-mode loss limit but below the multiplier one;
  // each level stands two clocks so the pin filter can see it
  initial begin
    reference_clock_in = 1'b0;
    forever begin
      repeat (2) @(posedge clk);
      if (ref_run) reference_clock_in <= !reference_clock_in;
    end
  end

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one-cycle write strobe, then one idle edge so that a following
  // strobe is never assigned twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
    @(posedge clk);
  endtask

  // read data taken at the edge that ends its only valid cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // staged word is always written whole: reset leaves it unknown
  task automatic upd(input logic [31:0] f, input logic [7:0] c);
    wr(`NCO_OFS_TUNING, f);
    wr(`NCO_OFS_CONTROL, {24'h0, c});
    core_update_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    core_update_strobe <= 1'b0;
    repeat (24) @(posedge clk);
  endtask

  task automatic t_reset;
    chk("powered_down", powered_down, 0);
    chk("mult_engaged", mult_engaged, 0);
    chk("comparator_enable", comparator_enable, 1);
    rd(`NCO_OFS_ACTIVE_FTW, v1);
    chk("active tuning", v1, 0);
    rd(`NCO_OFS_PHASE_ACC, v1);
    chk("accumulator", v1, 0);
    chk("sample", dac_true_output, 10'h3ff);
    rd(8'h40, v1);
    chk("unmapped read", v1, 0);
    $display("reset test done");
  endtask

  task automatic t_phase;
    upd(32'h0, 8'h80);
    chk("half turn", dac_true_output < 10'h200, 1);
    chk("complement", dac_complement_output,
        10'h3ff - dac_true_output);
    upd(32'h0, 8'h00);
    chk("zero phase", dac_true_output, 10'h3ff);
    $display("phase test done");
  endtask

  task automatic t_freq;
    upd(FTW_A, 8'h00);
    rd(`NCO_OFS_ACTIVE_FTW, v1);
    chk("active tuning", v1, FTW_A);
    rd(`NCO_OFS_TUNING, v2);
    chk("staged tuning", v2, FTW_A);
    wr(`NCO_OFS_ACTIVE_FTW, 32'h1234_5678);
    rd(`NCO_OFS_ACTIVE_FTW, v1);
    chk("read-only tuning", v1, FTW_A);
    rd(`NCO_OFS_PHASE_ACC, v1);
    rd(`NCO_OFS_PHASE_ACC, v2);
    chk("step with wrap", v2 - v1, FTW_A + FTW_A);
    upd(32'h0, 8'h00);
    rd(`NCO_OFS_PHASE_ACC, v1);
    rd(`NCO_OFS_PHASE_ACC, v2);
    chk("held phase", v2, v1);
    chk("phase kept", v1 != 0, 1);
    $display("frequency test done");
  endtask

  task automatic t_latency;
    wr(`NCO_OFS_TUNING, FTW_B);
    wr(`NCO_OFS_CONTROL, 32'h01);
    core_update_strobe <= 1'b1;
    n = 0;
    while (mult_engaged !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
      if (n == 4) core_update_strobe <= 1'b0;
    end
    chk("phase delay", n >= 13 && n <= 19, 1);
    rd(`NCO_OFS_ACTIVE_FTW, v1);
    chk("old tuning", v1, 0);
    repeat (10) @(posedge clk);
    rd(`NCO_OFS_ACTIVE_FTW, v1);
    chk("new tuning", v1, FTW_B);
    upd(FTW_B, 8'h00);
    repeat (60) @(posedge clk);
    $display("latency test done");
  endtask

  task automatic t_power;
    upd(FTW_B, 8'h04);
    chk("powered_down", powered_down, 1);
    rd(`NCO_OFS_STATUS, v1);
    chk("status pd", v1, 32'h1 << `NCO_STS_PD_BIT);
    rd(`NCO_OFS_PHASE_ACC, v1);
    rd(`NCO_OFS_PHASE_ACC, v2);
    chk("frozen phase", v2, v1);
    upd(FTW_B, 8'h00);
    chk("powered up", powered_down, 0);
    ref_run <= 1'b0;
    repeat (25) @(posedge clk);
    chk("loss down", powered_down, 1);
    chk("loss comparator", comparator_enable, 0);
    rd(`NCO_OFS_STATUS, v1);
    chk("status lost", v1, 32'h1 << `NCO_STS_LOST_BIT);
    rd(`NCO_OFS_PHASE_ACC, v1);
    rd(`NCO_OFS_PHASE_ACC, v2);
    chk("loss frozen", v2, v1);
    ref_run <= 1'b1;
    repeat (30) @(posedge clk);
    chk("still waiting", comparator_enable, 0);
    repeat (50) @(posedge clk);
    chk("resumed", comparator_enable, 1);
    chk("resumed up", powered_down, 0);
    $display("power test done");
  endtask

  task automatic t_stall;
    stall <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`NCO_OFS_PHASE_ACC, v1);
    rd(`NCO_OFS_PHASE_ACC, v2);
    chk("stalled phase", v2, v1);
    chk("valid held", dac_valid, 1);
    v1 = {16'h0, count_q};
    stall <= 1'b0;
    repeat (5) @(posedge clk);
    chk("drained", {16'h0, count_q} - v1, 4);
    $display("stall test done");
  endtask

  // a hang ends the run through the usual verdict
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    finish_test;
  end

  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    core_update_strobe = 1'b0;
    stall = 1'b0;
    ref_run = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_phase;
    t_freq;
    t_latency;
    t_power;
    t_stall;
    finish_test;
  end
endmodule

`default_nettype wire
